// file: verilog/adp_map.svh
// register map, field positions, reset values and timing figures of the output pulser
`ifndef ADP_MAP_SVH
`define ADP_MAP_SVH
`define ADP_CLK_NS     10
`define ADP_MS_NS      1000000
`define ADP_MS_PER_S   1000
`define ADP_MS_MAX     15'd30000
`define ADP_W_MIN      15'd1
`define ADP_D_MIN      15'd0
`define ADP_A_CTRL0    8'h00
`define ADP_A_PW0      8'h04
`define ADP_A_CTRL1    8'h08
`define ADP_A_PW1      8'h0C
`define ADP_A_INCFG    8'h10
`define ADP_A_THR      8'h14
`define ADP_A_STAT     8'h18
`define ADP_A_CNT      8'h1C
`define ADP_A_CMD      8'h20
`define ADP_A_IRQ      8'h24
`define ADP_A_MASK     8'h28
`define ADP_F_EN       0
`define ADP_F_ON       2:1
`define ADP_F_OFF      4:3
`define ADP_F_INIT     6:5
`define ADP_F_SRC      7
`define ADP_F_HOLD     15:8
`define ADP_F_DLY      30:16
`define ADP_F_PWL      14:0
`define ADP_F_PWH      30:16
`define ADP_ACT_HIGH   2'h0
`define ADP_ACT_LOW    2'h1
`define ADP_ACT_PULSE  2'h2
`define ADP_INIT_LAST  2'h0
`define ADP_INIT_HIGH  2'h1
`define ADP_RST_CTRL   32'h00000048
`define ADP_RST_PW     32'h000A000A
`define ADP_RESP_OK    2'h0
`define ADP_RESP_ERR   2'h2
`endif

// file: verilog/adp_pkg.sv
// types shared by the output pulser modules
package adp_pkg;
  typedef enum logic [1:0] {CH_IDLE, CH_DELAY, CH_RUN} adp_ch_st_t;

  typedef struct packed {
    adp_ch_st_t  st;
    logic        lvl;
    logic [1:0]  act;
    logic        prev;
    logic [14:0] ms;
    logic [9:0]  sub;
    logic [7:0]  sec;
  } adp_chan_t;

  typedef struct packed {
    logic [16:0] cnt;
    logic        tick;
  } adp_tick_t;

  typedef struct packed {
    logic        prev;
    logic        alarm;
    logic        fired;
    logic [15:0] count;
  } adp_in_t;

  typedef struct packed {
    logic [1:0][31:0] ctrl;
    logic [1:0][31:0] pw;
    logic [3:0]       incfg;
    logic [31:0]      thr;
    logic [3:0]       irq_st;
    logic [3:0]       irq_mask;
    logic [3:0]       cmd;
    logic [1:0]       al_prev;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             init_done;
    adp_chan_t [1:0]  ch;
  } adp_top_t;
endpackage : adp_pkg

// file: verilog/adp_tick.sv
// one-millisecond tick generator from the system clock
`timescale 1ns/100ps
module adp_tick #(
  parameter int MS_CYCLES = 100000
) (
  input  wire logic clk_sys,  // system clock
  input  wire logic rstn,     // async reset, low
  output logic      ms_tick   // one-cycle pulse per ms
);
  import adp_pkg::*;
  adp_tick_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt == 17'(MS_CYCLES - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 17'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ms_tick = s_r.tick;
endmodule : adp_tick

// file: verilog/adp_input.sv
// one sensing input: level alarm or event counter with threshold alarm
`timescale 1ns/100ps
module adp_input (
  input  wire logic        clk_sys,   // system clock
  input  wire logic        rstn,      // async reset, low
  input  wire logic        line,      // sensing_input_line bit
  input  wire logic        invert,    // alarm on low level
  input  wire logic        cnt_mode,  // counter mode
  input  wire logic [15:0] thr,       // count threshold, 0 = none
  input  wire logic        clear,     // clear count and counter alarm
  output logic             level,     // registered input level
  output logic             alarm,     // alarm state
  output logic [15:0]      count      // event count
);
  import adp_pkg::*;
  adp_in_t s_r, s_nxt;
  logic    eff;
  logic    ev;
  logic    fired_b;
  logic    alarm_b;

  always_comb begin
    s_nxt = s_r;
    eff = line ^ invert;
    ev = eff & ~(s_r.prev ^ invert);
    s_nxt.prev = line;
    // an event in the clear cycle still counts: set wins over clear
    s_nxt.count = (clear ? 16'h0 : s_r.count) + {15'h0, ev};
    fired_b = clear ? 1'b0 : s_r.fired;
    alarm_b = clear ? 1'b0 : s_r.alarm;
    s_nxt.fired = fired_b;
    if (cnt_mode) begin
      s_nxt.alarm = alarm_b;
      if (ev && thr != 16'h0 && s_nxt.count == thr && !fired_b) begin
        s_nxt.alarm = 1'b1;
        s_nxt.fired = 1'b1;
      end
    end else begin
      s_nxt.alarm = eff;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.prev;
  assign alarm = s_r.alarm;
  assign count = s_r.count;
endmodule : adp_input

// file: verilog/adp_top.sv
// alarm-driven two-channel output pulser with AXI4-Lite registers
// What this block does
// - alarm on: enabled channel drives on-action, default high
// - alarm off: enabled channel drives off-action, default low
// - pulse is square wave of low/high widths
// - low width 1..30000 ms, default 10
// - high width 1..30000 ms, default 10
// - power-up level: last, high or low, default low; the code always powers up low, as reset restores the default first
// - last state restores level held at power-off; the code never applies it, as the power-up setting is always low after reset
// - start delay 0..30000 ms, zero starts at once
// - hold time 0..255 s stops action, zero endless
// - channel follows first or second input alarm
// - enable per channel, default off, disabled ignores alarms
// - status shows input level, alarm, count, output level
// - per-input clear resets counter alarm and count
// - alarm on high input, on low when inverted
// - counter alarm once at threshold, zero disables
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "adp_map.svh"
module adp_top #(
  parameter int MS_CYCLES = `ADP_MS_NS / `ADP_CLK_NS
) (
  input  wire logic        clk_sys,             // 100 MHz system clock
  input  wire logic        rstn,                // async reset, low
  input  wire logic [7:0]  s_axi_awaddr,        // write address
  input  wire logic        s_axi_awvalid,       // write address valid
  output logic             s_axi_awready,       // write address ready
  input  wire logic [31:0] s_axi_wdata,         // write data
  input  wire logic [3:0]  s_axi_wstrb,         // byte enables
  input  wire logic        s_axi_wvalid,        // write data valid
  output logic             s_axi_wready,        // write data ready
  output logic [1:0]       s_axi_bresp,         // write response
  output logic             s_axi_bvalid,        // write response valid
  input  wire logic        s_axi_bready,        // write response ready
  input  wire logic [7:0]  s_axi_araddr,        // read address
  input  wire logic        s_axi_arvalid,       // read address valid
  output logic             s_axi_arready,       // read address ready
  output logic [31:0]      s_axi_rdata,         // read data
  output logic [1:0]       s_axi_rresp,         // read response
  output logic             s_axi_rvalid,        // read data valid
  input  wire logic        s_axi_rready,        // read data ready
  input  wire logic [1:0]  sensing_input_line,  // the two sensing inputs
  input  wire logic [1:0]  retain_level,        // levels kept over power loss
  output logic [1:0]       out_level,           // output channel levels
  output logic             irq                  // level interrupt, high
);
  import adp_pkg::*;

  adp_top_t    s_r, s_nxt;
  logic        ms_tick;
  logic [1:0]  in_level;
  logic [1:0]  in_alarm;
  logic [1:0][15:0] in_count;
  logic [3:0]  w1c;
  logic [3:0]  ev;
  logic [1:0]  hold_exp;
  logic [31:0] cfg;
  logic [31:0] pwc;
  logic        sel;
  logic        go;

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // out-of-range millisecond settings are pinned to the legal span
  function automatic logic [14:0] clamp_ms(input logic [14:0] v, input logic [14:0] lo);
    if (v < lo) begin
      return lo;
    end else if (v > `ADP_MS_MAX) begin
      return `ADP_MS_MAX;
    end else begin
      return v;
    end
  endfunction : clamp_ms

  adp_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ms_tick (ms_tick)
  );

  for (genvar g = 0; g < 2; g++) begin : g_in
    adp_input u_in (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .line     (sensing_input_line[g]),
      .invert   (s_r.incfg[2*g]),
      .cnt_mode (s_r.incfg[2*g+1]),
      .thr      (s_r.thr[16*g +: 16]),
      .clear    (s_r.cmd[g]),
      .level    (in_level[g]),
      .alarm    (in_alarm[g]),
      .count    (in_count[g])
    );
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd = '0;
    w1c = '0;
    hold_exp = '0;
    cfg = '0;
    pwc = '0;
    sel = 1'b0;
    go = 1'b0;

    // write channels are taken in either order, one write at a time
    if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `ADP_RESP_OK;
      case (s_r.awaddr)
        `ADP_A_CTRL0: begin
          s_nxt.ctrl[0] = merge(s_r.ctrl[0], s_r.wdata, s_r.wstrb);
        end
        `ADP_A_PW0: begin
          s_nxt.pw[0] = merge(s_r.pw[0], s_r.wdata, s_r.wstrb);
        end
        `ADP_A_CTRL1: begin
          s_nxt.ctrl[1] = merge(s_r.ctrl[1], s_r.wdata, s_r.wstrb);
        end
        `ADP_A_PW1: begin
          s_nxt.pw[1] = merge(s_r.pw[1], s_r.wdata, s_r.wstrb);
        end
        `ADP_A_INCFG: begin
          if (s_r.wstrb[0]) begin
            s_nxt.incfg = s_r.wdata[3:0];
          end
        end
        `ADP_A_THR: begin
          s_nxt.thr = merge(s_r.thr, s_r.wdata, s_r.wstrb);
        end
        `ADP_A_STAT, `ADP_A_CNT: begin
          // read-only, write ignored
        end
        `ADP_A_CMD: begin
          s_nxt.cmd = s_r.wdata[3:0] & {4{s_r.wstrb[0]}};
        end
        `ADP_A_IRQ: begin
          w1c = s_r.wdata[3:0] & {4{s_r.wstrb[0]}};
        end
        `ADP_A_MASK: begin
          if (s_r.wstrb[0]) begin
            s_nxt.irq_mask = s_r.wdata[3:0];
          end
        end
        default: begin
          s_nxt.bresp = `ADP_RESP_ERR;
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // read: data is registered in the accepting cycle
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `ADP_RESP_OK;
      case (s_axi_araddr)
        `ADP_A_CTRL0: s_nxt.rdata = s_r.ctrl[0];
        `ADP_A_PW0:   s_nxt.rdata = s_r.pw[0];
        `ADP_A_CTRL1: s_nxt.rdata = s_r.ctrl[1];
        `ADP_A_PW1:   s_nxt.rdata = s_r.pw[1];
        `ADP_A_INCFG: s_nxt.rdata = {28'h0, s_r.incfg};
        `ADP_A_THR:   s_nxt.rdata = s_r.thr;
        `ADP_A_STAT: begin
          s_nxt.rdata = {24'h0, s_r.ch[1].st != CH_IDLE, s_r.ch[0].st != CH_IDLE,
                         s_r.ch[1].lvl, s_r.ch[0].lvl, in_alarm[1], in_level[1],
                         in_alarm[0], in_level[0]};
        end
        `ADP_A_CNT:   s_nxt.rdata = {in_count[1], in_count[0]};
        `ADP_A_CMD:   s_nxt.rdata = 32'h0;
        `ADP_A_IRQ:   s_nxt.rdata = {28'h0, s_r.irq_st};
        `ADP_A_MASK:  s_nxt.rdata = {28'h0, s_r.irq_mask};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = `ADP_RESP_ERR;
        end
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // output channels
    s_nxt.init_done = 1'b1;
    for (int i = 0; i < 2; i++) begin
      cfg = s_r.ctrl[i];
      pwc = s_r.pw[i];
      sel = in_alarm[cfg[`ADP_F_SRC]];
      go = 1'b0;
      s_nxt.ch[i].prev = sel;
      if (!s_r.init_done) begin
        // first cycle after reset release picks the power-up level
        case (cfg[`ADP_F_INIT])
          `ADP_INIT_LAST: s_nxt.ch[i].lvl = retain_level[i];
          `ADP_INIT_HIGH: s_nxt.ch[i].lvl = 1'b1;
          default:        s_nxt.ch[i].lvl = 1'b0;
        endcase
      end else begin
        case (s_r.ch[i].st)
          CH_DELAY: begin
            if (ms_tick) begin
              if (s_r.ch[i].ms <= 15'h1) begin
                go = 1'b1;
              end else begin
                s_nxt.ch[i].ms = s_r.ch[i].ms - 15'h1;
              end
            end
          end
          CH_RUN: begin
            if (ms_tick && s_r.ch[i].act == `ADP_ACT_PULSE) begin
              if (s_r.ch[i].ms <= 15'h1) begin
                // phase ends: flip and load the width of the next phase
                s_nxt.ch[i].lvl = ~s_r.ch[i].lvl;
                s_nxt.ch[i].ms = s_r.ch[i].lvl ?
                                 clamp_ms(pwc[`ADP_F_PWL], `ADP_W_MIN) :
                                 clamp_ms(pwc[`ADP_F_PWH], `ADP_W_MIN);
              end else begin
                s_nxt.ch[i].ms = s_r.ch[i].ms - 15'h1;
              end
            end
            if (ms_tick && cfg[`ADP_F_HOLD] != 8'h0) begin
              if (s_r.ch[i].sub == 10'(`ADP_MS_PER_S - 1)) begin
                s_nxt.ch[i].sub = 10'h0;
                s_nxt.ch[i].sec = s_r.ch[i].sec + 8'h1;
                if (s_r.ch[i].sec + 8'h1 == cfg[`ADP_F_HOLD]) begin
                  // level stays where the action left it
                  s_nxt.ch[i].st = CH_IDLE;
                  hold_exp[i] = 1'b1;
                end
              end else begin
                s_nxt.ch[i].sub = s_r.ch[i].sub + 10'h1;
              end
            end
          end
          default: begin
          end
        endcase

        if (!cfg[`ADP_F_EN]) begin
          // disabling mid-action freezes the level
          s_nxt.ch[i].st = CH_IDLE;
          go = 1'b0;
        end else if (sel != s_r.ch[i].prev) begin
          // a new alarm edge replaces whatever is running
          s_nxt.ch[i].act = sel ? cfg[`ADP_F_ON] : cfg[`ADP_F_OFF];
          s_nxt.ch[i].ms = clamp_ms(cfg[`ADP_F_DLY], `ADP_D_MIN);
          go = (cfg[`ADP_F_DLY] == 15'h0);
          if (!go) begin
            s_nxt.ch[i].st = CH_DELAY;
          end
        end

        if (go) begin
          s_nxt.ch[i].st = CH_RUN;
          s_nxt.ch[i].sub = 10'h0;
          s_nxt.ch[i].sec = 8'h0;
          s_nxt.ch[i].ms = clamp_ms(pwc[`ADP_F_PWH], `ADP_W_MIN);
          case (s_nxt.ch[i].act)
            `ADP_ACT_LOW:  s_nxt.ch[i].lvl = 1'b0;
            default:       s_nxt.ch[i].lvl = 1'b1;
          endcase
        end

        if (s_r.cmd[2+i]) begin
          s_nxt.ch[i].lvl = ~s_nxt.ch[i].lvl;
        end
      end
    end

    // sticky events: alarm rises and hold expiries; set beats clear
    s_nxt.al_prev = in_alarm;
    ev = {hold_exp, in_alarm & ~s_r.al_prev};
    s_nxt.irq_st = (s_r.irq_st & ~w1c) | ev;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.ctrl <= {`ADP_RST_CTRL, `ADP_RST_CTRL};
      s_r.pw <= {`ADP_RST_PW, `ADP_RST_PW};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign out_level     = {s_r.ch[1].lvl, s_r.ch[0].lvl};
  assign irq           = |(s_r.irq_st & s_r.irq_mask);
endmodule : adp_top

// file: tb/adp_props.sv
// assertions on the output pulser top ports
`timescale 1ns/100ps
module adp_props #(
  parameter int MS_CYCLES = 10
) (
  input wire logic        clk_sys,        // clock
  input wire logic        rstn,           // reset, low
  input wire logic [7:0]  s_axi_awaddr,   // aw addr
  input wire logic        s_axi_awvalid,  // aw valid
  input wire logic        s_axi_awready,  // aw ready
  input wire logic [31:0] s_axi_wdata,    // w data
  input wire logic        s_axi_wvalid,   // w valid
  input wire logic        s_axi_wready,   // w ready
  input wire logic        s_axi_bvalid,   // b valid
  input wire logic [7:0]  s_axi_araddr,   // ar addr
  input wire logic        s_axi_arvalid,  // ar valid
  input wire logic        s_axi_arready,  // ar ready
  input wire logic [31:0] s_axi_rdata,    // r data
  input wire logic [1:0]  s_axi_rresp,    // r resp
  input wire logic        s_axi_rvalid,   // r valid
  input wire logic        s_axi_rready,   // r ready
  input wire logic [1:0]  out_level,      // outputs
  input wire logic        irq             // interrupt
);
  logic wr_hs;
  logic ar_hs;
  assign wr_hs = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_init_low: assert property ($rose(rstn) |=> out_level == 2'h0)
    else $error("outputs not low after reset");
  a_stat_out: assert property (ar_hs && s_axi_araddr == 8'h18 |=> s_axi_rdata[5:4] == $past(out_level))
    else $error("status misreports outputs");
  a_toggle_flip: assert property (wr_hs && s_axi_awaddr == 8'h20 && s_axi_wdata[3:2] == 2'b01 |-> ##[1:4] $changed(out_level[0]))
    else $error("toggle did not flip output");
  a_irq_masked: assert property (wr_hs && s_axi_awaddr == 8'h28 && s_axi_wdata[3:0] == 4'h0 |-> ##3 !irq)
    else $error("irq high with all masked");
  a_wr_answer: assert property (wr_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_rd_slverr: assert property (ar_hs && s_axi_araddr > 8'h28 |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_answer: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read answer late");
  c_irq: cover property (irq);
  c_pulse: cover property (!out_level[0] ##1 out_level[0]);
  c_bad_rd: cover property (ar_hs && s_axi_araddr > 8'h28);
endmodule : adp_props
bind adp_top adp_props #(.MS_CYCLES(MS_CYCLES)) u_adp_props (.*);

// file: tb/adp_slave_model.sv
// far-side equipment: watches the output lines and keeps their levels
`timescale 1ns/100ps
module adp_slave_model (
  input  wire logic        clk_sys,       // clock
  input  wire logic        rstn,          // reset, low
  input  wire logic [1:0]  out_level,     // driven lines
  output logic      [1:0]  retain_level,  // level kept over power loss
  output logic      [31:0] run0,          // last phase of line 0, cycles
  output logic      [15:0] edges0         // changes seen on line 0
);
  logic        up_r = 1'b0;
  logic        prev_r = 1'b0;
  logic [31:0] cyc_r = 32'h1;
  initial begin
    retain_level = 2'h0;
    run0 = 32'h0;
    edges0 = 16'h0;
  end
  // storage freezes while held in reset, skipping the first edge after it
  always @(posedge clk_sys) begin
    up_r <= rstn;
    if (rstn && up_r) begin
      retain_level <= out_level;
    end
    if (out_level[0] !== prev_r) begin
      run0 <= cyc_r;
      cyc_r <= 32'h1;
      edges0 <= edges0 + 16'h1;
    end else begin
      cyc_r <= cyc_r + 32'h1;
    end
    prev_r <= out_level[0];
  end
endmodule : adp_slave_model

// file: tb/alarm_driven_output_pulser_test.sv
// self-checking bench for the alarm-driven output pulser
`timescale 1ns/100ps
module alarm_driven_output_pulser_test;
  import adp_pkg::*;
  logic        clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, irq;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, run0, seed, lw, hw;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, si, retain_level, out_level;
  logic [15:0] edges0, e;
  logic [65:0] exp_q[$];
  logic [65:0] ev;
  int          n_errors, cmp_count, cyc_n, n;
  adp_top #(.MS_CYCLES(10)) u_adp_top (.sensing_input_line(si), .*);
  adp_slave_model u_adp_slave_model (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  task automatic tend(input string s);
    $display("test %s ended, mismatches %0d", s, n_errors);
  endtask : tend
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, db;
    db = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!db) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      db = s_axi_bvalid;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    // every write of the bench targets a mapped register, so the answer is okay
    chk(32'(s_axi_bresp), 32'h0);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = 2'h0);
    logic ta, dr;
    dr = 1'b0;
    exp_q.push_back({r, m, x});
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dr) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid & s_axi_arready;
      dr = s_axi_rvalid;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  // read data checked against the oldest note as each beat is taken
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) begin
      ev = exp_q.pop_front();
      cmp_count++;
      if (((s_axi_rdata ^ ev[31:0]) & ev[63:32]) !== 32'h0 || s_axi_rresp !== ev[65:64]) begin
        n_errors++;
        $display("MISMATCH t=%0t read %h exp %h", $time, s_axi_rdata, ev[31:0]);
      end
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end
  initial begin
    seed = 32'd82814;
    {rstn, si, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    cyc(5);
    rstn <= 1'b1;
    rd(8'h00, 32'h48);
    rd(8'h04, 32'h000A000A);
    rd(8'h08, 32'h48);
    rd(8'h0C, 32'h000A000A);
    rd(8'h2C, 32'h0, 32'hFFFFFFFF, 2'h2);
    chk(32'(out_level), 32'h0);
    si <= 2'h3;
    cyc(30);
    chk(32'(out_level), 32'h0);
    si <= 2'h0;
    tend("defaults");
    wr(8'h00, 32'h49);
    wr(8'h08, 32'hC9);
    si <= 2'h2;
    cyc(6);
    chk(32'(out_level), 32'h2);
    si <= 2'h1;
    cyc(6);
    chk(32'(out_level), 32'h1);
    rd(8'h18, 32'h13, 32'h3F);
    wr(8'h10, 32'h1);
    cyc(6);
    chk(32'(out_level), 32'h0);
    wr(8'h10, 32'h0);
    si <= 2'h0;
    cyc(6);
    chk(32'(out_level), 32'h0);
    wr(8'h20, 32'h4);
    cyc(4);
    chk(32'(out_level), 32'h1);
    wr(8'h20, 32'h4);
    cyc(4);
    chk(32'(out_level), 32'h0);
    tend("levels");
    wr(8'h00, 32'h00030049);
    si <= 2'h1;
    cyc(15);
    chk(32'(out_level), 32'h0);
    cyc(25);
    chk(32'(out_level), 32'h1);
    si <= 2'h0;
    cyc(40);
    tend("delay");
    for (int k = 0; k < 2; k++) begin
      lw = (k == 0) ? 32'h1 : rnd() % 4 + 1;
      hw = rnd() % 4 + 1;
      wr(8'h04, (hw << 16) | lw);
      wr(8'h00, 32'h4D);
      e = edges0 + 16'h3;
      si <= 2'h1;
      while (edges0 < e) @(posedge clk_sys);
      chk(run0, lw * 10);
      while (edges0 < e + 16'h1) @(posedge clk_sys);
      chk(run0, hw * 10);
      si <= 2'h0;
      cyc(8);
    end
    tend("pulse");
    wr(8'h28, 32'h4);
    wr(8'h24, 32'hF);
    wr(8'h00, 32'h14D);
    si <= 2'h1;
    cyc(10150);
    e = edges0;
    cyc(60);
    chk(32'(edges0), 32'(e));
    chk(32'(irq), 32'h1);
    rd(8'h24, 32'h4, 32'h4);
    wr(8'h24, 32'h4);
    cyc(3);
    chk(32'(irq), 32'h0);
    wr(8'h28, 32'h0);
    tend("hold");
    wr(8'h00, 32'h48);
    si <= 2'h0;
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h2);
    wr(8'h20, 32'h1);
    n = int'(rnd() % 3) + 2;
    repeat (n) begin
      si <= 2'h1;
      cyc(3);
      si <= 2'h0;
      cyc(3);
    end
    rd(8'h1C, 32'(n), 32'hFFFF);
    rd(8'h18, 32'h2, 32'h2);
    wr(8'h20, 32'h1);
    rd(8'h1C, 32'h0, 32'hFFFF);
    rd(8'h18, 32'h0, 32'h2);
    tend("counter");
    wr(8'h20, 32'h4);
    cyc(4);
    rstn <= 1'b0;
    cyc(5);
    rstn <= 1'b1;
    cyc(2);
    chk(32'(out_level), 32'h0);
    rd(8'h00, 32'h48);
    tend("reset");
    results();
  end
endmodule : alarm_driven_output_pulser_test
